// ---- hdl/fcser_pkg.sv ----
package fcser_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_SECURITY = 8'h04;
  localparam logic [7:0] ADDR_INDEX = 8'h08;
  localparam logic [7:0] ADDR_RESERVED = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG = 8'h10;
  localparam logic [7:0] ADDR_FAULT_CFG = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_FAULT_STAT = 8'h1c;
  localparam logic [7:0] ADDR_EVENT_CTRL = 8'h20;
  // ==========================================================
  // field positions
  localparam int BIT_DONE = 7;
  localparam int BIT_ACCESS_ERROR_FLAG = 5;
  localparam int BIT_PVIOL = 4;
  localparam int BIT_BUSY = 3;
  localparam int BIT_IGNORE_SINGLE_FAULT = 4;
  localparam int BIT_DBL = 1;
  localparam int BIT_SGL = 0;
  localparam int INDEX_WIDTH = 3;
  // ==========================================================
  // codes and reset values
  localparam logic [1:0] CODE_OPEN = 2'h2;
  localparam logic [7:0] SEC_ALL_SET = 8'hff;
  localparam logic [7:0] RESET_SEC = 8'hff;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [2:0] RESET_INDEX = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ---- hdl/fcser_regs.sv ----
`timescale 1ns/10ps
module fcser_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic load_valid,
  input wire logic [7:0] load_security_byte,
  input wire logic load_double_fault,
  input wire logic [1:0] load_status,
  input wire logic backdoor_unsecure,
  input wire logic cmd_complete,
  input wire logic [1:0] cmd_error_status,
  input wire logic seq_violation,
  input wire logic prot_violation,
  input wire logic array_read,
  input wire logic ecc_single,
  input wire logic ecc_double,
  input wire logic read_collision,
  output logic cmd_launch,
  output logic [2:0] index_field,
  output logic unsecured,
  output logic backdoor_allowed,
  output logic done_irq,
  output logic single_fault_irq,
  output logic double_fault_irq
);
  // ==========================================================
  // decode helper
  function automatic logic code_open(input logic [1:0] code);
    code_open = (code == fcser_pkg::CODE_OPEN);
  endfunction

  // ==========================================================
  // bus state
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic wr_en;
  logic [7:0] wdat;

  // ==========================================================
  // register state
  logic [7:0] security_register_reg, security_register_next;
  logic [2:0] index_reg, index_next;
  logic done_irq_enable_reg, done_irq_enable_next;
  logic ignore_single_fault_reg, ignore_single_fault_next;
  logic force_double_fault_reg, force_double_fault_next;
  logic force_single_fault_reg, force_single_fault_next;
  logic double_fault_irq_enable_reg, double_fault_irq_enable_next;
  logic single_fault_irq_enable_reg, single_fault_irq_enable_next;
  logic command_done_flag_reg, command_done_flag_next;
  logic access_error_flag_reg, access_error_flag_next;
  logic protect_violation_flag_reg, protect_violation_flag_next;
  logic [1:0] completion_status_reg, completion_status_next;
  logic double_fault_flag_reg, double_fault_flag_next;
  logic single_fault_flag_reg, single_fault_flag_next;
  logic rd_pend_reg, rd_pend_next;
  logic rd_sgl_reg, rd_sgl_next;
  logic rd_dbl_reg, rd_dbl_next;
  logic rd_col_reg, rd_col_next;
  logic launch_reg, launch_next;
  logic unsecured_reg, unsecured_next;
  logic backdoor_reg, backdoor_next;
  logic done_irq_reg, done_irq_next;
  logic sgl_irq_reg, sgl_irq_next;
  logic dbl_irq_reg, dbl_irq_next;
  logic hreadyout_reg, hreadyout_next;
  logic hresp_reg, hresp_next;
  logic [7:0] status_view;

  assign wr_en = wr_pend_reg;
  assign wdat = hwdata[7:0];

  // ==========================================================
  // ahb-lite slave, zero wait states, always okay
  always_comb begin
    wr_pend_next = 1'b0;
    addr_next = addr_reg;
    hrdata_next = 32'h00000000;
    hreadyout_next = 1'b1;
    hresp_next = 1'b0;
    if (hsel && hready && htrans == fcser_pkg::HTRANS_NONSEQ) begin
      addr_next = haddr[7:0];
      wr_pend_next = hwrite;
      if (!hwrite) begin
        if (haddr[7:0] == fcser_pkg::ADDR_SECURITY) begin
          hrdata_next[7:0] = security_register_reg;
        end else if (haddr[7:0] == fcser_pkg::ADDR_INDEX) begin
          hrdata_next[fcser_pkg::INDEX_WIDTH-1:0] = index_reg;
        end else if (haddr[7:0] == fcser_pkg::ADDR_RESERVED) begin
          hrdata_next = 32'h00000000;
        end else if (haddr[7:0] == fcser_pkg::ADDR_CONFIG) begin
          hrdata_next[fcser_pkg::BIT_DONE] = done_irq_enable_reg;
          hrdata_next[fcser_pkg::BIT_IGNORE_SINGLE_FAULT] = ignore_single_fault_reg;
          hrdata_next[fcser_pkg::BIT_DBL] = force_double_fault_reg;
          hrdata_next[fcser_pkg::BIT_SGL] = force_single_fault_reg;
        end else if (haddr[7:0] == fcser_pkg::ADDR_FAULT_CFG) begin
          hrdata_next[fcser_pkg::BIT_DBL] = double_fault_irq_enable_reg;
          hrdata_next[fcser_pkg::BIT_SGL] = single_fault_irq_enable_reg;
        end else if (haddr[7:0] == fcser_pkg::ADDR_STATUS) begin
          hrdata_next[7:0] = status_view;
        end else if (haddr[7:0] == fcser_pkg::ADDR_FAULT_STAT) begin
          hrdata_next[fcser_pkg::BIT_DBL] = double_fault_flag_reg;
          hrdata_next[fcser_pkg::BIT_SGL] = single_fault_flag_reg;
        end else begin
          hrdata_next = 32'h00000000;
        end
      end
    end
  end

  // ==========================================================
  // status view: busy equals done low, bit 2 reserved zero
  always_comb begin
    status_view = 8'h00;
    status_view[fcser_pkg::BIT_DONE] = command_done_flag_reg;
    status_view[fcser_pkg::BIT_ACCESS_ERROR_FLAG] = access_error_flag_reg;
    status_view[fcser_pkg::BIT_PVIOL] = protect_violation_flag_reg;
    status_view[fcser_pkg::BIT_BUSY] = !command_done_flag_reg;
    status_view[1:0] = completion_status_reg;
  end

  // ==========================================================
  // register next-state
  always_comb begin
    security_register_next = security_register_reg;
    index_next = index_reg;
    done_irq_enable_next = done_irq_enable_reg;
    ignore_single_fault_next = ignore_single_fault_reg;
    force_double_fault_next = force_double_fault_reg;
    force_single_fault_next = force_single_fault_reg;
    double_fault_irq_enable_next = double_fault_irq_enable_reg;
    single_fault_irq_enable_next = single_fault_irq_enable_reg;
    command_done_flag_next = command_done_flag_reg;
    access_error_flag_next = access_error_flag_reg;
    protect_violation_flag_next = protect_violation_flag_reg;
    completion_status_next = completion_status_reg;
    double_fault_flag_next = double_fault_flag_reg;
    single_fault_flag_next = single_fault_flag_reg;
    launch_next = 1'b0;
    // reset sequence load
    if (load_valid) begin
      security_register_next = load_double_fault ? fcser_pkg::SEC_ALL_SET : load_security_byte;
      completion_status_next = load_status;
    end
    if (backdoor_unsecure) begin
      security_register_next[1:0] = fcser_pkg::CODE_OPEN;
    end
    // software writes
    if (wr_en) begin
      if (addr_reg == fcser_pkg::ADDR_INDEX) begin
        index_next = wdat[fcser_pkg::INDEX_WIDTH-1:0];
      end else if (addr_reg == fcser_pkg::ADDR_CONFIG) begin
        done_irq_enable_next = wdat[fcser_pkg::BIT_DONE];
        ignore_single_fault_next = wdat[fcser_pkg::BIT_IGNORE_SINGLE_FAULT];
        force_double_fault_next = wdat[fcser_pkg::BIT_DBL];
        force_single_fault_next = wdat[fcser_pkg::BIT_SGL];
      end else if (addr_reg == fcser_pkg::ADDR_FAULT_CFG) begin
        double_fault_irq_enable_next = wdat[fcser_pkg::BIT_DBL];
        single_fault_irq_enable_next = wdat[fcser_pkg::BIT_SGL];
      end else if (addr_reg == fcser_pkg::ADDR_STATUS) begin
        if (wdat[fcser_pkg::BIT_ACCESS_ERROR_FLAG]) begin
          access_error_flag_next = 1'b0;
        end
        if (wdat[fcser_pkg::BIT_PVIOL]) begin
          protect_violation_flag_next = 1'b0;
        end
        if (wdat[fcser_pkg::BIT_DONE] && command_done_flag_reg &&
            !access_error_flag_reg && !protect_violation_flag_reg) begin
          command_done_flag_next = 1'b0;
          completion_status_next = 2'h0;
          launch_next = 1'b1;
        end
      end else if (addr_reg == fcser_pkg::ADDR_FAULT_STAT) begin
        if (wdat[fcser_pkg::BIT_DBL]) begin
          double_fault_flag_next = 1'b0;
        end
        if (wdat[fcser_pkg::BIT_SGL]) begin
          single_fault_flag_next = 1'b0;
        end
      end
    end
    // hardware events win over clears
    if (seq_violation) begin
      access_error_flag_next = 1'b1;
    end
    if (prot_violation) begin
      protect_violation_flag_next = 1'b1;
    end
    if (!command_done_flag_reg && (cmd_complete || seq_violation || prot_violation)) begin
      command_done_flag_next = 1'b1;
      completion_status_next = completion_status_reg | cmd_error_status;
    end
    // fault flags one cycle after the read
    if (rd_pend_reg) begin
      if (rd_col_reg) begin
        double_fault_flag_next = 1'b1;
        single_fault_flag_next = !ignore_single_fault_reg || single_fault_flag_next;
      end else if (rd_dbl_reg) begin
        double_fault_flag_next = 1'b1;
      end else if (rd_sgl_reg && !ignore_single_fault_reg) begin
        single_fault_flag_next = 1'b1;
      end
      if (force_double_fault_reg) begin
        double_fault_flag_next = 1'b1;
      end
      if (force_single_fault_reg && !ignore_single_fault_reg) begin
        single_fault_flag_next = 1'b1;
      end
    end
  end

  // ==========================================================
  // read capture for one-cycle flag delay
  always_comb begin
    rd_pend_next = array_read;
    rd_sgl_next = array_read && ecc_single;
    rd_dbl_next = array_read && ecc_double;
    rd_col_next = array_read && read_collision;
  end

  // ==========================================================
  // output levels
  always_comb begin
    unsecured_next = code_open(security_register_reg[1:0]);
    backdoor_next = code_open(security_register_reg[7:6]);
    done_irq_next = done_irq_enable_reg && command_done_flag_reg;
    sgl_irq_next = single_fault_irq_enable_reg && single_fault_flag_reg;
    dbl_irq_next = double_fault_irq_enable_reg && double_fault_flag_reg;
  end

  // ==========================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= fcser_pkg::RESET_ZERO;
      hrdata_reg <= 32'h00000000;
      security_register_reg <= fcser_pkg::RESET_SEC;
      index_reg <= fcser_pkg::RESET_INDEX;
      done_irq_enable_reg <= 1'b0;
      ignore_single_fault_reg <= 1'b0;
      force_double_fault_reg <= 1'b0;
      force_single_fault_reg <= 1'b0;
      double_fault_irq_enable_reg <= 1'b0;
      single_fault_irq_enable_reg <= 1'b0;
      command_done_flag_reg <= 1'b1;
      access_error_flag_reg <= 1'b0;
      protect_violation_flag_reg <= 1'b0;
      completion_status_reg <= 2'h0;
      double_fault_flag_reg <= 1'b0;
      single_fault_flag_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_sgl_reg <= 1'b0;
      rd_dbl_reg <= 1'b0;
      rd_col_reg <= 1'b0;
      launch_reg <= 1'b0;
      unsecured_reg <= 1'b0;
      backdoor_reg <= 1'b0;
      done_irq_reg <= 1'b0;
      sgl_irq_reg <= 1'b0;
      dbl_irq_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      hrdata_reg <= hrdata_next;
      security_register_reg <= security_register_next;
      index_reg <= index_next;
      done_irq_enable_reg <= done_irq_enable_next;
      ignore_single_fault_reg <= ignore_single_fault_next;
      force_double_fault_reg <= force_double_fault_next;
      force_single_fault_reg <= force_single_fault_next;
      double_fault_irq_enable_reg <= double_fault_irq_enable_next;
      single_fault_irq_enable_reg <= single_fault_irq_enable_next;
      command_done_flag_reg <= command_done_flag_next;
      access_error_flag_reg <= access_error_flag_next;
      protect_violation_flag_reg <= protect_violation_flag_next;
      completion_status_reg <= completion_status_next;
      double_fault_flag_reg <= double_fault_flag_next;
      single_fault_flag_reg <= single_fault_flag_next;
      rd_pend_reg <= rd_pend_next;
      rd_sgl_reg <= rd_sgl_next;
      rd_dbl_reg <= rd_dbl_next;
      rd_col_reg <= rd_col_next;
      launch_reg <= launch_next;
      unsecured_reg <= unsecured_next;
      backdoor_reg <= backdoor_next;
      done_irq_reg <= done_irq_next;
      sgl_irq_reg <= sgl_irq_next;
      dbl_irq_reg <= dbl_irq_next;
      hreadyout_reg <= hreadyout_next;
      hresp_reg <= hresp_next;
    end
  end

  // ==========================================================
  // outputs
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign cmd_launch = launch_reg;
  assign index_field = index_reg;
  assign unsecured = unsecured_reg;
  assign backdoor_allowed = backdoor_reg;
  assign done_irq = done_irq_reg;
  assign single_fault_irq = sgl_irq_reg;
  assign double_fault_irq = dbl_irq_reg;
endmodule

// ---- tb/fcser_regs_props.sv ----
`timescale 1ns/10ps
// ==========================================
// port checker for the register block
module fcser_regs_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic load_valid,
  input wire logic [7:0] load_security_byte,
  input wire logic load_double_fault,
  input wire logic backdoor_unsecure,
  input wire logic array_read,
  input wire logic ecc_double,
  input wire logic cmd_launch,
  input wire logic unsecured,
  input wire logic backdoor_allowed,
  input wire logic single_fault_irq,
  input wire logic double_fault_irq
);
  logic ph_reg, ph_next, wr_reg, wr_next, launch_wr, bd_ok, sec_ok;
  logic [7:0] adr_reg, adr_next, cfg_reg, cfg_next, fcfg_reg, fcfg_next;
  // ==========================================
  // shadow of the address phase and of the fault controls
  always_comb begin
    ph_next = hsel && hready && htrans == fcser_pkg::HTRANS_NONSEQ;
    wr_next = hwrite;
    adr_next = haddr[7:0];
    cfg_next = (ph_reg && wr_reg && adr_reg == fcser_pkg::ADDR_CONFIG) ? hwdata[7:0] : cfg_reg;
    fcfg_next = (ph_reg && wr_reg && adr_reg == fcser_pkg::ADDR_FAULT_CFG) ? hwdata[7:0] : fcfg_reg;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ph_reg, wr_reg, adr_reg, cfg_reg, fcfg_reg} <= '0;
    end else begin
      {ph_reg, wr_reg, adr_reg, cfg_reg, fcfg_reg} <= {ph_next, wr_next, adr_next, cfg_next, fcfg_next};
    end
  end
  assign launch_wr = ph_reg && wr_reg && adr_reg == fcser_pkg::ADDR_STATUS && hwdata[7];
  assign bd_ok = load_security_byte[7:6] == 2'h2;
  assign sec_ok = load_security_byte[1:0] == 2'h2;
  // ==========================================
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_BACKDOOR: assert property (load_valid && !load_double_fault |-> ##2 backdoor_allowed == $past(bd_ok, 2))
    else $error("backdoor enable wrong after load");
  AST_SECURE: assert property (load_valid && !load_double_fault |-> ##2 unsecured == $past(sec_ok, 2))
    else $error("security state wrong after load");
  AST_LOAD_DOUBLE: assert property (load_valid && load_double_fault |-> ##2 !unsecured && !backdoor_allowed)
    else $error("double fault load left part open");
  AST_UNSECURE: assert property (backdoor_unsecure |-> ##2 unsecured)
    else $error("backdoor unsecure not applied");
  AST_LAUNCH_CAUSE: assert property (cmd_launch |-> $past(launch_wr) || $past(launch_wr, 2))
    else $error("launch without launch write");
  AST_DOUBLE_IRQ: assert property (array_read && ecc_double && fcfg_reg[1] |-> ##[2:3] double_fault_irq)
    else $error("double fault interrupt missing");
  AST_FORCE_SINGLE: assert property (array_read && cfg_reg[0] && !cfg_reg[4] && fcfg_reg[0] |-> ##[2:3] single_fault_irq)
    else $error("forced single fault interrupt missing");
  AST_READ_ZERO: assert property (ph_reg && !wr_reg |-> hrdata[31:8] == 24'h0 && !(adr_reg == fcser_pkg::ADDR_STATUS && hrdata[2]) && !(adr_reg == fcser_pkg::ADDR_RESERVED && hrdata != 32'h0))
    else $error("reserved read bits not zero");
  AST_IRQ_LEVEL: assert property (double_fault_irq && !(ph_reg && wr_reg) && !$past(ph_reg && wr_reg) |=> double_fault_irq)
    else $error("double fault interrupt dropped");
endmodule
bind fcser_regs fcser_regs_props u_fcser_regs_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .load_valid, .load_security_byte, .load_double_fault, .backdoor_unsecure, .array_read, .ecc_double, .cmd_launch,
  .unsecured, .backdoor_allowed, .single_fault_irq, .double_fault_irq);

// ---- tb/fcser_regs_tb.sv ----
`timescale 1ns/10ps
// ==========================================
// self-checking bench
module fcser_regs_tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, load_valid, load_double_fault, backdoor_unsecure;
  logic cmd_complete, seq_violation, prot_violation, array_read, ecc_single, ecc_double, read_collision, cmd_launch;
  logic unsecured, backdoor_allowed, done_irq, single_fault_irq, double_fault_irq;
  logic [31:0] haddr, hwdata, hrdata, lfsr, rdv;
  logic [1:0] htrans, load_status, cmd_error_status;
  logic [2:0] hsize, index_field;
  logic [7:0] load_security_byte, b, r, cfg, expf;
  logic [7:0] ra [8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h40};
  logic [7:0] rv [8] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
  int failures, total_checks, cycles, launches;
  assign hready = hreadyout;
  fcser_regs u_fcser_regs (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .load_valid, .load_security_byte, .load_double_fault, .load_status, .backdoor_unsecure,
    .cmd_complete, .cmd_error_status, .seq_violation, .prot_violation, .array_read, .ecc_single, .ecc_double,
    .read_collision, .cmd_launch, .index_field, .unsecured, .backdoor_allowed, .done_irq, .single_fault_irq,
    .double_fault_irq);
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cmd_launch === 1'b1) launches++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_fault(input logic [7:0] v);
    return {6'h0, v[1] | (v[4] & ~v[3]) | v[5], ~v[2] & (v[0] | v[3] | v[5])};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, fcser_pkg::HTRANS_NONSEQ, w};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(name, rdv, exp);
    chk("bus response", {30'h0, hreadyout, hresp}, 32'h2);
  endtask
  task automatic ev(input logic [5:0] m);
    @(posedge hclk);
    {load_valid, backdoor_unsecure, cmd_complete, seq_violation, prot_violation, array_read} <= m;
    @(posedge hclk);
    {load_valid, backdoor_unsecure, cmd_complete, seq_violation, prot_violation, array_read} <= 6'h0;
    repeat (4) @(posedge hclk);
  endtask
  // ==========================================
  // main sequence
  initial begin
    {hsel, hwrite, load_valid, load_double_fault, backdoor_unsecure, cmd_complete, seq_violation} = '0;
    {prot_violation, array_read, ecc_single, ecc_double, read_collision, htrans, load_status} = '0;
    {haddr, hwdata, cmd_error_status, load_security_byte} = '0;
    hsize = 3'h2;
    lfsr = 32'hb844;
    hresetn = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdc("reset value", ra[i], {24'h0, rv[i]});
    chk("done irq", done_irq, 0);
    for (int c = 0; c < 4; c++) begin
      lfsr = next_rand(lfsr);
      b = {c[1:0], lfsr[3:0], c[1:0]};
      load_security_byte <= b;
      ev(6'h20);
      chk("backdoor", backdoor_allowed, c == 2);
      chk("unsecured", unsecured, c == 2);
      rdc("security", fcser_pkg::ADDR_SECURITY, {24'h0, b});
    end
    {load_double_fault, load_status} <= 3'h6;
    ev(6'h20);
    rdc("security fault", fcser_pkg::ADDR_SECURITY, 32'hff);
    chk("backdoor fault", backdoor_allowed, 0);
    load_double_fault <= 1'b0;
    ev(6'h10);
    chk("unsecured forced", unsecured, 1);
    rdc("security forced", fcser_pkg::ADDR_SECURITY, 32'hfe);
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      bus(fcser_pkg::ADDR_INDEX, 1'b1, lfsr);
      rdc("index", fcser_pkg::ADDR_INDEX, {29'h0, lfsr[2:0]});
      chk("index port", index_field, lfsr[2:0]);
      bus(fcser_pkg::ADDR_RESERVED, 1'b1, lfsr);
      rdc("reserved", fcser_pkg::ADDR_RESERVED, 0);
      bus(fcser_pkg::ADDR_CONFIG, 1'b1, lfsr);
      rdc("config", fcser_pkg::ADDR_CONFIG, lfsr & 32'h93);
    end
    bus(fcser_pkg::ADDR_STATUS, 1'b1, 32'h4c);
    rdc("status rsvd", fcser_pkg::ADDR_STATUS, 32'h82);
    bus(fcser_pkg::ADDR_CONFIG, 1'b1, 32'h80);
    repeat (2) @(posedge hclk);
    chk("done irq on", done_irq, 1);
    bus(fcser_pkg::ADDR_STATUS, 1'b1, 32'h80);
    rdc("running", fcser_pkg::ADDR_STATUS, 32'h08);
    chk("done irq off", done_irq, 0);
    cmd_error_status <= 2'h1;
    ev(6'h08);
    rdc("completed", fcser_pkg::ADDR_STATUS, 32'h81);
    chk("done irq back", done_irq, 1);
    cmd_error_status <= 2'h0;
    for (int k = 0; k < 2; k++) begin
      bus(fcser_pkg::ADDR_STATUS, 1'b1, 32'h80);
      ev(k ? 6'h02 : 6'h04);
      bus(fcser_pkg::ADDR_STATUS, 1'b1, 32'h80);
      bus(fcser_pkg::ADDR_STATUS, 1'b1, 32'h00);
      rdc("violation", fcser_pkg::ADDR_STATUS, k ? 32'h90 : 32'ha0);
      bus(fcser_pkg::ADDR_STATUS, 1'b1, k ? 32'h10 : 32'h20);
      rdc("cleared", fcser_pkg::ADDR_STATUS, 32'h80);
    end
    chk("launches", launches, 3);
    for (int i = 0; i < 12; i++) begin
      lfsr = next_rand(lfsr);
      r = (i == 0) ? 8'hc3 : lfsr[7:0];
      cfg = {3'h0, r[2], 2'h0, r[1:0]};
      bus(fcser_pkg::ADDR_CONFIG, 1'b1, {24'h0, cfg});
      bus(fcser_pkg::ADDR_FAULT_CFG, 1'b1, {30'h0, r[7:6]});
      {ecc_single, ecc_double, read_collision} <= {r[3], r[4] & ~r[3], r[5]};
      ev(6'h01);
      expf = exp_fault(r);
      chk("single irq", single_fault_irq, expf[0] & r[6]);
      chk("double irq", double_fault_irq, expf[1] & r[7]);
      bus(fcser_pkg::ADDR_FAULT_STAT, 1'b1, 32'h0);
      rdc("fault flags", fcser_pkg::ADDR_FAULT_STAT, {24'h0, expf});
      rdc("force kept", fcser_pkg::ADDR_CONFIG, {24'h0, cfg});
      bus(fcser_pkg::ADDR_FAULT_STAT, 1'b1, 32'h3);
      rdc("flags cleared", fcser_pkg::ADDR_FAULT_STAT, 0);
      chk("irqs dropped", {single_fault_irq, double_fault_irq}, 0);
    end
    complete_run();
  end
endmodule
